// ===== core/rqfc_pkg.sv
// Constants, register map and types for the receive queue flow control block
`default_nettype none
package rqfc_pkg;
  // Queue occupancy width, counted in packet units
  localparam int unsigned QW = 14;
  // Register byte offsets
  localparam logic [7:0] OFS_GENERAL_CONFIG  = 8'h00;
  localparam logic [7:0] OFS_MAC_FLOW_CTRL   = 8'h04;
  localparam logic [7:0] OFS_RXQ_SIZE        = 8'h08;
  localparam logic [7:0] OFS_RXQ_HIGH_THR    = 8'h0C;
  localparam logic [7:0] OFS_RXQ_LOW_THR     = 8'h10;
  localparam logic [7:0] OFS_RXQ_LATCHED     = 8'h14;
  localparam logic [7:0] OFS_RXQ_LEVEL       = 8'h18;
  localparam logic [7:0] OFS_TXQ_HIGH_THR    = 8'h1C;
  // General config fields
  localparam int unsigned GC_AUTO_FLOW_BIT   = 0;
  localparam int unsigned GC_JAM_EN_BIT      = 1;
  localparam int unsigned GC_FULL_DUPLEX_BIT = 2;
  // MAC flow control fields
  localparam int unsigned FC_PAUSE_REQ_BIT   = 0;
  localparam int unsigned FC_FCE_BIT         = 1;
  localparam int unsigned FC_PAUSE_RESP_BIT  = 2;
  localparam int unsigned FC_TIMER_LSB       = 16;
  // Latched status fields
  localparam int unsigned LS_RXQ_HIGH_BIT    = 0;
  localparam int unsigned LS_RXQ_LOW_BIT     = 1;
  localparam int unsigned LS_RXQ_OVFL_BIT    = 2;
  localparam int unsigned LS_TXQ_HIGH_BIT    = 3;
  // Level register fields
  localparam int unsigned LV_HIGH_STATE_BIT  = 16;
  localparam int unsigned LV_OVFL_STATE_BIT  = 17;
  // Reset values
  localparam logic        AUTO_FLOW_RST      = 1'b1;
  localparam logic        FULL_DUPLEX_RST    = 1'b1;
  localparam logic [15:0] PAUSE_TIMER_RST    = 16'h0050;
  localparam logic [QW-1:0] RXQ_SIZE_RST     = 14'h0100;
  localparam logic [QW-1:0] RXQ_HIGH_RST     = 14'h00A0;
  localparam logic [QW-1:0] RXQ_LOW_RST      = 14'h0040;
  localparam logic [QW-1:0] TXQ_HIGH_RST     = 14'h00A0;
  // Reserved multicast destination of generated pause frames
  localparam logic [47:0] PAUSE_DEST_ADDR    = 48'h0180_6200_0001;
  // Bytes jammed at the head of each received frame, minus one
  localparam logic [1:0]  JAM_LAST_BYTE      = 2'h3;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;
  // Jam sequencer states
  typedef enum logic [1:0] {
    JAM_IDLE   = 2'b01,
    JAM_ACTIVE = 2'b10
  } rqfc_jam_state_type;
endpackage
`default_nettype wire

// ===== core/rqfc_arbiter.sv
// Round-robin SDRAM access arbiter between the MAC and HDLC requesters
`default_nettype none
module rqfc_arbiter (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic mac_req_i,
  input  wire logic hdlc_req_i,
  output var  logic mac_grant_o,
  output var  logic hdlc_grant_o
);
  logic last_mac;

  // Grant is held until its requester drops; the idle bus goes to the one not served last
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mac_grant_o  <= 1'b0;
      hdlc_grant_o <= 1'b0;
      last_mac     <= 1'b0;
    end else if (mac_grant_o) begin
      mac_grant_o <= mac_req_i;
    end else if (hdlc_grant_o) begin
      hdlc_grant_o <= hdlc_req_i;
    end else if (mac_req_i && (!hdlc_req_i || !last_mac)) begin
      mac_grant_o <= 1'b1;
      last_mac    <= 1'b1;
    end else if (hdlc_req_i) begin
      hdlc_grant_o <= 1'b1;
      last_mac     <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== core/rqfc_top.sv
// Receive queue flow control: pause and jam generation with AXI4-Lite registers
//
// Functional notes
// - Arbiter serves both HDLC and MAC SDRAM transfer requests.
// - In automatic mode hardware owns enable and pause bits; software writes ignored.
// - Automatic pause or jam depends only on high threshold crossing.
// - Automatic flow setting is on after reset.
// - Low threshold only flags congestion clearing, never drives pause or jam.
// - Full duplex automatic: one pause per received frame while above threshold.
// - Pause frames go to the reserved pause multicast address.
// - Overflow sets a latched flag; new frames refused while overflowed.
// - A software bit decides whether received pause frames are obeyed.
// - Transmit queue gets threshold status only, no flow control.
// - Half duplex: jam first four bytes of each new frame when high.
// - Frame in progress at crossing is not jammed; next frame is.
// - Jamming continues while above high threshold, stops once below.
// - Half duplex ignores pause bit; full duplex ignores jam bit.
// - Latched threshold and overflow flags clear when their register is read.
//
// Implementation choices: the address map and the AXI4-Lite register port.
`default_nettype none
module rqfc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output var  logic        s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output var  logic        s_axi_wready_o,
  output var  logic [1:0]  s_axi_bresp_o,
  output var  logic        s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output var  logic        s_axi_arready_o,
  output var  logic [31:0] s_axi_rdata_o,
  output var  logic [1:0]  s_axi_rresp_o,
  output var  logic        s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  // MAC receive side and queue events
  input  wire logic        rx_frame_start_i,
  input  wire logic        rx_byte_valid_i,
  input  wire logic        rx_pkt_enq_i,
  input  wire logic        rx_pkt_deq_i,
  input  wire logic [13:0] tx_queue_level_i,
  input  wire logic        pause_sent_i,
  output var  logic        rx_jam_o,
  output var  logic        rx_frame_drop_o,
  output var  logic        pause_req_o,
  output var  logic [15:0] pause_timer_o,
  output var  logic [47:0] pause_dest_addr_o,
  output var  logic        flow_ctrl_enable_o,
  output var  logic        pause_response_control_o,
  // SDRAM arbitration
  input  wire logic        mac_sdram_req_i,
  input  wire logic        hdlc_sdram_req_i,
  output var  logic        mac_sdram_grant_o,
  output var  logic        hdlc_sdram_grant_o
);
  localparam int unsigned QW = rqfc_pkg::QW;

  logic          auto_flow_enable;
  logic          jam_enable;
  logic          full_duplex;
  logic          pause_request_busy;
  logic          flow_ctrl_enable;
  logic          pause_response_control;
  logic [15:0]   pause_timer;
  logic [QW-1:0] rx_queue_size;
  logic [QW-1:0] rx_queue_high_threshold;
  logic [QW-1:0] rx_queue_low_threshold;
  logic [QW-1:0] tx_queue_high_threshold;
  logic [3:0]    rx_queue_latched_status;
  logic [QW-1:0] occupancy;
  logic          ovfl_state;
  logic          high_prev;
  logic          low_prev;
  logic          tx_high_prev;
  logic          aw_held;
  logic          w_held;
  logic [7:0]    aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic [1:0]    jam_cnt;
  rqfc_pkg::rqfc_jam_state_type jam_state;

  logic          high_state;
  logic          below_low;
  logic          tx_high;
  logic          q_full;
  logic          wr_fire;
  logic          rd_fire;
  logic          wr_hit;
  logic [31:0]   wr_val;
  logic [3:0]    set_bits;
  logic [3:0]    clr_bits;
  logic          frame_jam;

  // Current value of a register, free of side effects
  function automatic logic [31:0] reg_value(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      rqfc_pkg::OFS_GENERAL_CONFIG: begin
        v[rqfc_pkg::GC_AUTO_FLOW_BIT]   = auto_flow_enable;
        v[rqfc_pkg::GC_JAM_EN_BIT]      = jam_enable;
        v[rqfc_pkg::GC_FULL_DUPLEX_BIT] = full_duplex;
      end
      rqfc_pkg::OFS_MAC_FLOW_CTRL: begin
        v[rqfc_pkg::FC_PAUSE_REQ_BIT]  = pause_request_busy;
        v[rqfc_pkg::FC_FCE_BIT]        = flow_ctrl_enable;
        v[rqfc_pkg::FC_PAUSE_RESP_BIT] = pause_response_control;
        v[rqfc_pkg::FC_TIMER_LSB +: 16] = pause_timer;
      end
      rqfc_pkg::OFS_RXQ_SIZE:     v[QW-1:0] = rx_queue_size;
      rqfc_pkg::OFS_RXQ_HIGH_THR: v[QW-1:0] = rx_queue_high_threshold;
      rqfc_pkg::OFS_RXQ_LOW_THR:  v[QW-1:0] = rx_queue_low_threshold;
      rqfc_pkg::OFS_RXQ_LATCHED:  v[3:0]    = rx_queue_latched_status;
      rqfc_pkg::OFS_RXQ_LEVEL: begin
        v[QW-1:0]                      = occupancy;
        v[rqfc_pkg::LV_HIGH_STATE_BIT] = high_state;
        v[rqfc_pkg::LV_OVFL_STATE_BIT] = ovfl_state;
      end
      rqfc_pkg::OFS_TXQ_HIGH_THR: v[QW-1:0] = tx_queue_high_threshold;
      default:                    v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // Address decode
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= rqfc_pkg::OFS_TXQ_HIGH_THR);
  endfunction

  // Queue conditions; the low threshold only feeds status
  assign high_state = occupancy > rx_queue_high_threshold;
  assign below_low  = occupancy < rx_queue_low_threshold;
  assign tx_high    = tx_queue_level_i > tx_queue_high_threshold;
  assign q_full     = occupancy >= rx_queue_size;

  // Bus strobes and byte-lane merge of the write data
  assign wr_fire = aw_held && w_held && !s_axi_bvalid_o;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign wr_hit  = wr_fire && mapped(aw_addr);
  always_comb begin
    wr_val = reg_value(aw_addr);
    for (int i = 0; i < 4; i++) begin
      if (w_strb[i]) begin
        wr_val[8*i +: 8] = w_data[8*i +: 8];
      end
    end
  end

  // AXI write address and data capture, in either order
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= 8'h00;
      w_data          <= 32'h0000_0000;
      w_strb          <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held         <= 1'b1;
        aw_addr         <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end else if (!aw_held && !s_axi_bvalid_o) begin
        s_axi_awready_o <= 1'b1;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held         <= 1'b1;
        w_data         <= s_axi_wdata_i;
        w_strb         <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end else if (!w_held && !s_axi_bvalid_o) begin
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // AXI write response
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= rqfc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= mapped(aw_addr) ? rqfc_pkg::RESP_OKAY : rqfc_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // AXI read channel; data sampled at the address handshake
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= 32'h0000_0000;
      s_axi_rresp_o   <= rqfc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= reg_value(s_axi_araddr_i);
      s_axi_rresp_o   <= mapped(s_axi_araddr_i) ? rqfc_pkg::RESP_OKAY : rqfc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid_o) begin
      s_axi_rvalid_o <= !s_axi_rready_i;
    end else begin
      s_axi_arready_o <= 1'b1;
    end
  end

  // Plain configuration registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      auto_flow_enable        <= rqfc_pkg::AUTO_FLOW_RST;
      jam_enable              <= 1'b0;
      full_duplex             <= rqfc_pkg::FULL_DUPLEX_RST;
      pause_response_control  <= 1'b0;
      pause_timer             <= rqfc_pkg::PAUSE_TIMER_RST;
      rx_queue_size           <= rqfc_pkg::RXQ_SIZE_RST;
      rx_queue_high_threshold <= rqfc_pkg::RXQ_HIGH_RST;
      rx_queue_low_threshold  <= rqfc_pkg::RXQ_LOW_RST;
      tx_queue_high_threshold <= rqfc_pkg::TXQ_HIGH_RST;
    end else if (wr_hit) begin
      case (aw_addr)
        rqfc_pkg::OFS_GENERAL_CONFIG: begin
          auto_flow_enable <= wr_val[rqfc_pkg::GC_AUTO_FLOW_BIT];
          jam_enable       <= wr_val[rqfc_pkg::GC_JAM_EN_BIT];
          full_duplex      <= wr_val[rqfc_pkg::GC_FULL_DUPLEX_BIT];
        end
        rqfc_pkg::OFS_MAC_FLOW_CTRL: begin
          pause_response_control <= wr_val[rqfc_pkg::FC_PAUSE_RESP_BIT];
          pause_timer            <= wr_val[rqfc_pkg::FC_TIMER_LSB +: 16];
        end
        rqfc_pkg::OFS_RXQ_SIZE:     rx_queue_size           <= wr_val[QW-1:0];
        rqfc_pkg::OFS_RXQ_HIGH_THR: rx_queue_high_threshold <= wr_val[QW-1:0];
        rqfc_pkg::OFS_RXQ_LOW_THR:  rx_queue_low_threshold  <= wr_val[QW-1:0];
        rqfc_pkg::OFS_TXQ_HIGH_THR: tx_queue_high_threshold <= wr_val[QW-1:0];
        default: ;
      endcase
    end
  end

  // Flow control enable: follows the high state in automatic mode, software otherwise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flow_ctrl_enable <= 1'b0;
    end else if (auto_flow_enable) begin
      flow_ctrl_enable <= high_state;
    end else if (wr_hit && aw_addr == rqfc_pkg::OFS_MAC_FLOW_CTRL) begin
      flow_ctrl_enable <= wr_val[rqfc_pkg::FC_FCE_BIT];
    end
  end

  // Pause request: set by hardware or software, cleared when the MAC has sent it; set wins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pause_request_busy <= 1'b0;
    end else if (!full_duplex) begin
      pause_request_busy <= 1'b0;
    end else if (auto_flow_enable && rx_frame_start_i && high_state) begin
      pause_request_busy <= 1'b1;
    end else if (!auto_flow_enable && flow_ctrl_enable && wr_hit &&
                 aw_addr == rqfc_pkg::OFS_MAC_FLOW_CTRL && wr_val[rqfc_pkg::FC_PAUSE_REQ_BIT]) begin
      pause_request_busy <= 1'b1;
    end else if (pause_sent_i) begin
      pause_request_busy <= 1'b0;
    end
  end

  // Receive queue occupancy and overflow state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      occupancy  <= '0;
      ovfl_state <= 1'b0;
    end else begin
      if (rx_pkt_enq_i && !q_full && !(rx_pkt_deq_i && occupancy != '0)) begin
        occupancy <= occupancy + 1'b1;
      end else if (rx_pkt_deq_i && occupancy != '0 && !(rx_pkt_enq_i && !q_full)) begin
        occupancy <= occupancy - 1'b1;
      end
      if (rx_pkt_enq_i && q_full && !rx_pkt_deq_i) begin
        ovfl_state <= 1'b1;
      end else if (rx_pkt_deq_i) begin
        ovfl_state <= 1'b0;
      end
    end
  end

  // Latched status: crossing and overflow events set, read clears, set wins over clear
  assign set_bits = {tx_high && !tx_high_prev,
                     rx_pkt_enq_i && q_full && !rx_pkt_deq_i,
                     below_low && !low_prev,
                     high_state && !high_prev};
  assign clr_bits = (rd_fire && s_axi_araddr_i == rqfc_pkg::OFS_RXQ_LATCHED) ? 4'hF : 4'h0;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_queue_latched_status <= 4'h0;
      high_prev               <= 1'b0;
      low_prev                <= 1'b1;
      tx_high_prev            <= 1'b0;
    end else begin
      rx_queue_latched_status <= (rx_queue_latched_status & ~clr_bits) | set_bits;
      high_prev               <= high_state;
      low_prev                <= below_low;
      tx_high_prev            <= tx_high;
    end
  end

  // Jam decision taken only at frame start, so a frame already running is spared
  assign frame_jam = !full_duplex &&
                     (auto_flow_enable ? high_state : (jam_enable && flow_ctrl_enable));

  // Jam sequencer: marks the first four bytes of the frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      jam_state <= rqfc_pkg::JAM_IDLE;
      jam_cnt   <= 2'h0;
      rx_jam_o  <= 1'b0;
    end else if (rx_frame_start_i) begin
      jam_cnt   <= 2'h0;
      jam_state <= frame_jam ? rqfc_pkg::JAM_ACTIVE : rqfc_pkg::JAM_IDLE;
      rx_jam_o  <= frame_jam;
    end else begin
      case (jam_state)
        rqfc_pkg::JAM_ACTIVE: begin
          if (rx_byte_valid_i) begin
            jam_cnt <= jam_cnt + 2'h1;
            if (jam_cnt == rqfc_pkg::JAM_LAST_BYTE) begin
              jam_state <= rqfc_pkg::JAM_IDLE;
              rx_jam_o  <= 1'b0;
            end
          end
        end
        default: begin
          jam_state <= rqfc_pkg::JAM_IDLE;
          rx_jam_o  <= 1'b0;
        end
      endcase
    end
  end

  // Frame refusal decided at frame start, held for the frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_frame_drop_o <= 1'b0;
    end else if (rx_frame_start_i) begin
      rx_frame_drop_o <= ovfl_state;
    end
  end

  // Registered MAC-facing outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pause_req_o              <= 1'b0;
      pause_timer_o            <= rqfc_pkg::PAUSE_TIMER_RST;
      pause_dest_addr_o        <= rqfc_pkg::PAUSE_DEST_ADDR;
      flow_ctrl_enable_o       <= 1'b0;
      pause_response_control_o <= 1'b0;
    end else begin
      pause_req_o              <= pause_request_busy && !pause_sent_i;
      pause_timer_o            <= pause_timer;
      pause_dest_addr_o        <= rqfc_pkg::PAUSE_DEST_ADDR;
      flow_ctrl_enable_o       <= flow_ctrl_enable;
      pause_response_control_o <= pause_response_control;
    end
  end

  // Shared SDRAM access for the MAC and HDLC paths
  rqfc_arbiter u_arbiter (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .mac_req_i    (mac_sdram_req_i),
    .hdlc_req_i   (hdlc_sdram_req_i),
    .mac_grant_o  (mac_sdram_grant_o),
    .hdlc_grant_o (hdlc_sdram_grant_o)
  );
endmodule
`default_nettype wire

// ===== bench/rqfc_monitor.sv
// Port-level checker for the receive queue flow control block
`default_nettype none
module rqfc_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        rx_frame_start_i,
  input wire logic        rx_byte_valid_i,
  input wire logic        rx_jam_o,
  input wire logic        rx_frame_drop_o,
  input wire logic        pause_req_o,
  input wire logic        pause_sent_i,
  input wire logic [47:0] pause_dest_addr_o,
  input wire logic        mac_sdram_grant_o,
  input wire logic        hdlc_sdram_grant_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] jam_cnt;
  // Bytes jammed so far in the current frame
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i || rx_frame_start_i) begin
      jam_cnt <= 3'h0;
    end else if (rx_byte_valid_i && rx_jam_o) begin
      jam_cnt <= jam_cnt + 3'h1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr_both; s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o; endsequence
  sequence s_rd_take; s_axi_arvalid_i && s_axi_arready_o; endsequence
  property p_wr_lat; s_wr_both |-> ##2 s_axi_bvalid_o; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response not two cycles after request");
  property p_rd_lat; s_rd_take |=> s_axi_rvalid_o; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data not one cycle after request");
  property p_dest; pause_dest_addr_o == 48'h0180_6200_0001; endproperty
  a_dest: assert property (p_dest) else $error("pause destination wrong");
  property p_pause_src; $rose(pause_req_o) |-> $past(rx_frame_start_i, 2) || $past(s_axi_bvalid_o); endproperty
  a_pause_src: assert property (p_pause_src) else $error("pause request without cause");
  property p_pause_drop; pause_sent_i && pause_req_o |=> !pause_req_o; endproperty
  a_pause_drop: assert property (p_pause_drop) else $error("pause request held after send");
  property p_jam_src; $rose(rx_jam_o) |-> $past(rx_frame_start_i); endproperty
  a_jam_src: assert property (p_jam_src) else $error("jam began inside a frame");
  property p_jam_len; rx_jam_o |-> jam_cnt < 3'h4; endproperty
  a_jam_len: assert property (p_jam_len) else $error("jam longer than four bytes");
  property p_jam_full; $fell(rx_jam_o) |-> jam_cnt == 3'h4 || $past(rx_frame_start_i); endproperty
  a_jam_full: assert property (p_jam_full) else $error("jam shorter than four bytes");
  property p_drop_src; $rose(rx_frame_drop_o) |-> $past(rx_frame_start_i); endproperty
  a_drop_src: assert property (p_drop_src) else $error("drop raised outside frame start");
  property p_arb_excl; !(mac_sdram_grant_o && hdlc_sdram_grant_o); endproperty
  a_arb_excl: assert property (p_arb_excl) else $error("both requesters granted");
endmodule
bind rqfc_top rqfc_monitor u_mon (.*);
`default_nettype wire

// ===== bench/rqfc_remote_node.sv
// Remote transmitting node with its MAC: sends frames and answers pause requests
`default_nettype none
module rqfc_remote_node (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [3:0] dly_i,
  input  wire logic       rx_jam_i,
  input  wire logic       pause_req_i,
  output var  logic       frame_start_o,
  output var  logic       byte_valid_o,
  output var  logic       pause_sent_o,
  output var  logic [3:0] jam_bytes_o,
  output var  logic [3:0] pause_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  initial {frame_start_o, byte_valid_o, pause_sent_o, jam_bytes_o, pause_cnt_o, wait_cnt} = '0;
  // Start strobe, then eight bytes back to back
  always @(posedge clk_i) begin
    if (go_i) begin
      frame_start_o <= 1'h1;
      @(posedge clk_i) frame_start_o <= 1'h0;
      byte_valid_o <= 1'h1;
      repeat (8) @(posedge clk_i);
      byte_valid_o <= 1'h0;
    end
  end
  // Bytes that arrived while the receiver jammed them
  always @(posedge clk_i) begin
    if (frame_start_o) jam_bytes_o <= 4'h0;
    else if (byte_valid_o && rx_jam_i) jam_bytes_o <= jam_bytes_o + 4'h1;
  end
  // Pause frame leaves dly_i + 1 cycles after the request, prompt or slow
  always @(posedge clk_i) begin
    pause_sent_o <= 1'h0;
    if (pause_req_i && !pause_sent_o) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt == dly_i) begin
        pause_sent_o <= 1'h1;
        pause_cnt_o  <= pause_cnt_o + 4'h1;
        wait_cnt     <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// Self-checking bench for the receive queue flow control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'h0, rst_i = 1'h1, go = 1'h0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rnd = 32'hAD2D_B19D;
  logic [3:0]  s_axi_wstrb_i = 4'hF, dly = 4'h0, jbytes, pcnt;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [13:0] tx_queue_level_i = 14'h0;
  logic [15:0] pause_timer_o;
  logic [47:0] pause_dest_addr_o;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0, s_axi_arvalid_i = 1'h0;
  logic s_axi_rready_i = 1'h0, rx_pkt_enq_i = 1'h0, rx_pkt_deq_i = 1'h0, mac_sdram_req_i = 1'h0;
  logic hdlc_sdram_req_i = 1'h0, rx_frame_start_i, rx_byte_valid_i, pause_sent_i, s_axi_awready_o;
  logic s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, rx_jam_o, rx_frame_drop_o;
  logic pause_req_o, flow_ctrl_enable_o, pause_response_control_o, mac_sdram_grant_o, hdlc_sdram_grant_o;
  logic [31:0] rv [4] = '{32'h5, 32'h0050_0000, 32'h100, 32'hA0};
  logic [33:0] expq [$];
  int bad_count = 0;
  int checks = 0;
  rqfc_top DUT (.*);
  rqfc_remote_node u_node (.clk_i, .go_i(go), .dly_i(dly), .rx_jam_i(rx_jam_o), .pause_req_i(pause_req_o),
    .frame_start_o(rx_frame_start_i), .byte_valid_o(rx_byte_valid_i), .pause_sent_o(pause_sent_i),
    .jam_bytes_o(jbytes), .pause_cnt_o(pcnt));
  // Free-running clock
  always #5 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Random arbiter requests and transmit queue fill, kept below its threshold
  always @(posedge clk_i) begin
    rnd <= lfsr(rnd);
    mac_sdram_req_i <= rnd[0];
    hdlc_sdram_req_i <= rnd[3];
    tx_queue_level_i <= {7'h00, rnd[12:6]};
  end
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic guard(input int n);
    if (n >= 100) begin
      bad_count++;
      results();
    end
  endtask
  // One register transfer; the expected answer is queued for the watcher
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    expq.push_back({r, w ? 32'h0 : d});
    s_axi_awaddr_i <= a;
    s_axi_araddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= w;
    s_axi_wvalid_i <= w;
    s_axi_bready_i <= w;
    s_axi_arvalid_i <= !w;
    s_axi_rready_i <= !w;
    for (n = 0; n < 100 && (w ? !s_axi_bvalid_o : !s_axi_rvalid_o); n++) begin
      @(posedge clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
    end
    guard(n);
    s_axi_bready_i <= 1'h0;
    s_axi_rready_i <= 1'h0;
    @(posedge clk_i);
  endtask
  // Answers are matched against the oldest queued expectation
  always @(posedge clk_i) begin
    if ((s_axi_bvalid_o && s_axi_bready_i) || (s_axi_rvalid_o && s_axi_rready_i)) begin
      if (expq.size() == 0) chk("answer count", 34'h1, 34'h0);
      else chk("answer", s_axi_bvalid_o ? {s_axi_bresp_o, 32'h0} : {s_axi_rresp_o, s_axi_rdata_o}, expq.pop_front());
    end
  end
  task automatic pkt(input logic e, input int n);
    repeat (n) begin
      rx_pkt_enq_i <= e;
      rx_pkt_deq_i <= !e;
      @(posedge clk_i);
      rx_pkt_enq_i <= 1'h0;
      rx_pkt_deq_i <= 1'h0;
      @(posedge clk_i);
    end
  endtask
  task automatic frame(input logic [3:0] d, input logic [3:0] jb);
    dly <= d;
    go <= 1'h1;
    @(posedge clk_i);
    go <= 1'h0;
    repeat (14) @(posedge clk_i);
    chk("jam bytes", jbytes, jb);
  endtask
  // Main sequence
  initial begin
    logic [13:0] low;
    int n;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    foreach (rv[i]) xfer(1'h0, 8'(i * 4), rv[i], 2'h0);
    xfer(1'h0, 8'h20, 32'h0, 2'h2);
    xfer(1'h1, 8'h24, 32'h1, 2'h2);
    xfer(1'h1, 8'h04, 32'h0050_0007, 2'h0);
    xfer(1'h0, 8'h04, 32'h0050_0004, 2'h0);
    chk("pause obey", pause_response_control_o, 1'h1);
    low = 14'h0010 + rnd[7:0];
    xfer(1'h1, 8'h08, 32'h4, 2'h0);
    xfer(1'h1, 8'h0C, 32'h2, 2'h0);
    xfer(1'h1, 8'h10, {18'h0, low}, 2'h0);
    xfer(1'h0, 8'h10, {18'h0, low}, 2'h0);
    xfer(1'h0, 8'h14, 32'h0, 2'h0);
    pkt(1'h1, 3);
    frame(4'h0, 4'h0);
    frame(4'h6, 4'h0);
    chk("pauses", pcnt, 4'h2);
    chk("timer", pause_timer_o, 16'h0050);
    xfer(1'h0, 8'h14, 32'h1, 2'h0);
    xfer(1'h0, 8'h14, 32'h0, 2'h0);
    xfer(1'h1, 8'h00, 32'h1, 2'h0);
    frame(4'h0, 4'h4);
    chk("pauses", pcnt, 4'h2);
    pkt(1'h0, 2);
    fork
      frame(4'h0, 4'h0);
      begin
        repeat (3) @(posedge clk_i);
        pkt(1'h1, 2);
      end
    join
    frame(4'h0, 4'h4);
    pkt(1'h0, 2);
    frame(4'h0, 4'h0);
    pkt(1'h1, 4);
    frame(4'h0, 4'h4);
    chk("drop", rx_frame_drop_o, 1'h1);
    xfer(1'h0, 8'h14, 32'h5, 2'h0);
    pkt(1'h0, 1);
    frame(4'h0, 4'h4);
    chk("drop", rx_frame_drop_o, 1'h0);
    xfer(1'h1, 8'h00, 32'h4, 2'h0);
    xfer(1'h1, 8'h04, 32'h0050_0002, 2'h0);
    xfer(1'h1, 8'h04, 32'h0050_0003, 2'h0);
    chk("flow enable", flow_ctrl_enable_o, 1'h1);
    for (n = 0; n < 100 && pcnt != 4'h3; n++) @(posedge clk_i);
    guard(n);
    results();
  end
endmodule
`default_nettype wire
